// ---- chipmode_pkg.sv ----
package chipmode_pkg;

    // special-function address of the chipmode configuration register
    localparam logic [7:0] CFG_ADDR = 8'hb2;

    // bit positions inside chipmode_config_reg
    localparam int ARM_BIT = 7;
    localparam int COMMIT_BIT = 6;
    localparam int RSV_HI_BIT = 5;
    localparam int RSV_LO_BIT = 3;
    localparam int FWE_BIT = 2;
    localparam int MIRROR_BIT = 1;
    localparam int SWAP_BIT = 0;

    // index of each protected bit in the voted pair
    localparam int FWE_IDX = 1;
    localparam int SWAP_IDX = 0;
    localparam int PROT_BITS = 2;

    // reset values, and the value read from the reserved bits
    localparam logic PROT_RESET = 1'b0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    localparam logic [2:0] RSV_READ = 3'h0;

    // delays in instruction cycles, and the width of their counters
    localparam int ARM_LIFE_CYC = 2;
    localparam int SWITCH_DELAY_CYC = 2;
    localparam int RESTORE_DELAY_CYC = 2;
    localparam int CNT_W = 2;

    // address boundaries of the swapped code map and the default data map
    localparam logic [15:0] BOOT_ROM_END = 16'h01ff;
    localparam logic [15:0] EXT_SRAM_END = 16'hf3ff;
    localparam logic [15:0] ONCHIP_RAM_BASE = 16'hf400;

    // chipmode encoding {flash_write_enable, swap}
    typedef enum logic [1:0] {
        CM_NORMAL = 2'h0,
        CM_RAM_EXEC = 2'h1,
        CM_BOOTSTRAP = 2'h2,
        CM_PROGRAMMING = 2'h3
    } chipmode_e;

    typedef enum logic [1:0] {
        CODE_EXT_FLASH,
        CODE_BOOT_ROM,
        CODE_EXT_SRAM,
        CODE_ONCHIP_RAM
    } code_target_e;

    typedef enum logic [1:0] {
        DATA_EXT_SRAM,
        DATA_ONCHIP_RAM,
        DATA_EXT_FLASH
    } data_target_e;

endpackage : chipmode_pkg

// ---- chipmode_map_if.sv ----
interface chipmode_map_if;
    import chipmode_pkg::*;

    logic swap;
    logic ram_map_en;
    logic [15:0] code_addr;
    logic [15:0] data_addr;
    code_target_e code_sel;
    data_target_e data_sel;

    modport ctrl (
        output swap,
        output ram_map_en,
        output code_addr,
        output data_addr,
        input code_sel,
        input data_sel
    );

    modport map (
        input swap,
        input ram_map_en,
        input code_addr,
        input data_addr,
        output code_sel,
        output data_sel
    );

endinterface : chipmode_map_if

// ---- tmr_bit.sv ----
module tmr_bit
    import chipmode_pkg::*;
#(
    parameter logic RESET_VAL = PROT_RESET
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic d_i,
    output logic q_o
);

    logic [2:0] latch_q;

    // majority of the three shadow latches
    assign q_o = (latch_q[0] & latch_q[1]) | (latch_q[0] & latch_q[2]) | (latch_q[1] & latch_q[2]);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            latch_q <= {3{RESET_VAL}};
        end else if (load_i) begin
            latch_q <= {3{d_i}};
        end else if (tick_i) begin
            latch_q <= {3{q_o}}; // R22
        end
    end

    a_vote_restore: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (tick_i && !load_i) |=> (latch_q == {3{$past(q_o)}})) // R22
        else $error("shadow latches not restored to voted value");

endmodule : tmr_bit

// ---- addr_map.sv ----
module addr_map
    import chipmode_pkg::*;
(
    chipmode_map_if.map m
);

    always_comb begin
        if (m.swap) begin
            if (m.code_addr <= BOOT_ROM_END) begin
                m.code_sel = CODE_BOOT_ROM; // R17
            end else if (m.code_addr <= EXT_SRAM_END) begin
                m.code_sel = CODE_EXT_SRAM; // R17
            end else begin
                m.code_sel = CODE_ONCHIP_RAM; // R18
            end
            m.data_sel = DATA_EXT_FLASH; // R19
        end else begin
            m.code_sel = CODE_EXT_FLASH; // R16
            if (m.ram_map_en && (m.data_addr >= ONCHIP_RAM_BASE)) begin
                m.data_sel = DATA_ONCHIP_RAM; // R16
            end else begin
                m.data_sel = DATA_EXT_SRAM; // R16
            end
        end
    end

endmodule : addr_map

// ---- chipmode_select_control.sv ----
// Summary of operation
// (R1) config register at B2, five control bits
// (R2) write-enable and swap change only by unlock
// (R3) reset/powerdown release latches program pin level
// (R4) software sets arm with new mode values
// (R5) arm bit self-clears after two cycles
// (R6) software commits in the very next instruction
// (R7) new mode active two cycles after commit
// (R8) commit bit write-only, reads zero
// (R9) reserved bits ignore writes, read undefined
// (R10) flash writes allowed only when enable set
// (R11) pin low clears write-enable next cycle
// (R12) unsequenced changes ignored, old state kept
// (R13) mirror bit shows program pin level
// (R14) pin low blocks setting write-enable
// (R15) pin high allows unlocked write-enable changes
// (R16) swap zero keeps default memory locations
// (R17) swap one remaps low code space
// (R18) swap one maps top code to RAM
// (R19) swap one maps data space to flash
// (R20) chipmode encoded by write-enable and swap
// (R21) register access blocks interrupt acceptance briefly
// (R22) protected bits voted from three latches
// (R23) stray or late commit is discarded
// (R24) reset or powerdown cancels pending unlock
module chipmode_select_control
    import chipmode_pkg::*;
#(
    parameter int ARM_LIFE = ARM_LIFE_CYC,
    parameter int SWITCH_DELAY = SWITCH_DELAY_CYC,
    parameter int RESTORE_DELAY = RESTORE_DELAY_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic instr_cycle_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic prog_enable_pin_i,
    input wire logic hw_powerdown_pin_n_i,
    input wire logic onchip_ram_map_enable_i,
    input wire logic [15:0] code_addr_i,
    input wire logic [15:0] data_addr_i,
    output chipmode_e chipmode_o,
    output logic flash_write_allow_o,
    output code_target_e code_sel_o,
    output data_target_e data_sel_o,
    output logic int_block_o
);

    if (ARM_LIFE < 1 || ARM_LIFE > 3 || SWITCH_DELAY < 1 || SWITCH_DELAY > 3
            || RESTORE_DELAY < 1 || RESTORE_DELAY > 3) begin : g_bad_param
        $error("delay parameters must lie in 1..3");
    end

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_ARMED,
        SW_SWITCHING
    } switch_state_e;

    localparam logic [CNT_W-1:0] ARM_CNT = CNT_W'(ARM_LIFE);
    localparam logic [CNT_W-1:0] SWITCH_CNT = CNT_W'(SWITCH_DELAY);
    localparam logic [CNT_W-1:0] RESTORE_CNT = CNT_W'(RESTORE_DELAY);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

    // pin synchronisers
    logic pin_meta_q;
    logic pin_sync_q;
    logic pd_meta_q;
    logic pd_sync_q;
    logic pd_prev_q;
    logic pd_release;
    logic strap_pending_q;
    logic hw_load;

    always_ff @(posedge clk_i) begin
        pin_meta_q <= prog_enable_pin_i;
        pin_sync_q <= pin_meta_q; // R13
        pd_meta_q <= hw_powerdown_pin_n_i;
        pd_sync_q <= pd_meta_q;
        pd_prev_q <= pd_sync_q;
    end

    assign pd_release = pd_sync_q & ~pd_prev_q;

    // strap captured on the first edge after reset release
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            strap_pending_q <= 1'b1;
        end else begin
            strap_pending_q <= 1'b0;
        end
    end

    assign hw_load = strap_pending_q | pd_release; // R3

    // register decode
    logic cfg_wr;
    logic cfg_rd;
    logic arm_wr;
    logic commit_wr;

    assign cfg_wr = sfr_wr_i && (sfr_addr_i == CFG_ADDR); // R1
    assign cfg_rd = sfr_rd_i && (sfr_addr_i == CFG_ADDR); // R1
    assign arm_wr = cfg_wr && sfr_wdata_i[ARM_BIT];
    assign commit_wr = cfg_wr && sfr_wdata_i[COMMIT_BIT];

    // unlock sequencer
    switch_state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic apply;
    logic arm_expire;

    assign apply = (state_q == SW_SWITCHING) && instr_cycle_i && (cnt_q == CNT_ONE); // R7
    assign arm_expire = (state_q == SW_ARMED) && instr_cycle_i && (cnt_q == CNT_ONE)
                        && !commit_wr && !arm_wr;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || pd_release) begin
            state_q <= SW_IDLE; // R24
            cnt_q <= CNT_ZERO;
        end else begin
            unique case (state_q)
                SW_IDLE: begin
                    if (arm_wr) begin
                        state_q <= SW_ARMED; // R4
                        cnt_q <= ARM_CNT;
                    end
                end
                SW_ARMED: begin
                    if (commit_wr) begin
                        state_q <= SW_SWITCHING; // R6
                        cnt_q <= SWITCH_CNT;
                    end else if (arm_wr) begin
                        cnt_q <= ARM_CNT;
                    end else if (instr_cycle_i) begin
                        if (cnt_q == CNT_ONE) begin
                            state_q <= SW_IDLE; // R5
                        end
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
                SW_SWITCHING: begin
                    if (instr_cycle_i) begin
                        if (cnt_q == CNT_ONE) begin
                            state_q <= SW_IDLE; // R7
                        end
                        cnt_q <= cnt_q - CNT_ONE;
                    end
                end
                default: begin
                    state_q <= SW_IDLE;
                    cnt_q <= CNT_ZERO;
                end
            endcase
        end
    end

    // protected bits, voted
    logic [PROT_BITS-1:0] act_load;
    logic [PROT_BITS-1:0] act_d;
    logic [PROT_BITS-1:0] act_q;

    // staged values visible to software until applied or restored
    logic stage_fwe_q;
    logic stage_swap_q;
    logic [CNT_W-1:0] restore_cnt_q;
    logic restore_now;

    assign restore_now = (instr_cycle_i && (state_q == SW_IDLE) && (restore_cnt_q == CNT_ONE))
                         || arm_expire; // R23

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            stage_fwe_q <= PROT_RESET;
            stage_swap_q <= PROT_RESET;
            restore_cnt_q <= CNT_ZERO;
        end else if (hw_load) begin
            stage_fwe_q <= pin_sync_q; // R3
            stage_swap_q <= act_q[SWAP_IDX];
            restore_cnt_q <= CNT_ZERO;
        end else if (commit_wr && (state_q != SW_SWITCHING)) begin
            // commit byte carries no mode bits, keep staged swap, keep staged write-enable only while pin high
            stage_fwe_q <= stage_fwe_q & pin_sync_q; // R14
        end else if (cfg_wr && (state_q != SW_SWITCHING)) begin
            stage_fwe_q <= sfr_wdata_i[FWE_BIT] & pin_sync_q; // R14
            stage_swap_q <= sfr_wdata_i[SWAP_BIT];
            restore_cnt_q <= RESTORE_CNT;
        end else if (restore_now) begin
            stage_fwe_q <= act_q[FWE_IDX]; // R12
            stage_swap_q <= act_q[SWAP_IDX]; // R12
            restore_cnt_q <= CNT_ZERO;
        end else begin
            if (instr_cycle_i && !pin_sync_q) begin
                stage_fwe_q <= 1'b0; // R11
            end
            if (instr_cycle_i && (restore_cnt_q != CNT_ZERO)) begin
                restore_cnt_q <= restore_cnt_q - CNT_ONE;
            end
        end
    end

    always_comb begin
        act_load[FWE_IDX] = hw_load || apply || (instr_cycle_i && !pin_sync_q && act_q[FWE_IDX]);
        if (hw_load) begin
            act_d[FWE_IDX] = pin_sync_q; // R3
        end else if (apply) begin
            act_d[FWE_IDX] = stage_fwe_q & pin_sync_q; // R15
        end else begin
            act_d[FWE_IDX] = 1'b0; // R11
        end
        act_load[SWAP_IDX] = apply && !hw_load; // R2
        act_d[SWAP_IDX] = stage_swap_q;
    end

    for (genvar i = 0; i < PROT_BITS; i++) begin : g_prot
        tmr_bit #(
            .RESET_VAL(PROT_RESET)
        ) u_tmr (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .tick_i(instr_cycle_i),
            .load_i(act_load[i]),
            .d_i(act_d[i]),
            .q_o(act_q[i])
        ); // R22
    end

    // address remapping
    chipmode_map_if map_bus ();

    assign map_bus.swap = act_q[SWAP_IDX];
    assign map_bus.ram_map_en = onchip_ram_map_enable_i;
    assign map_bus.code_addr = code_addr_i;
    assign map_bus.data_addr = data_addr_i;

    addr_map u_map (
        .m(map_bus.map)
    );

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            chipmode_o <= CM_NORMAL;
            flash_write_allow_o <= 1'b0;
            code_sel_o <= CODE_EXT_FLASH;
            data_sel_o <= DATA_EXT_SRAM;
        end else begin
            chipmode_o <= chipmode_e'({act_q[FWE_IDX], act_q[SWAP_IDX]}); // R20
            flash_write_allow_o <= act_q[FWE_IDX]; // R10
            code_sel_o <= map_bus.code_sel;
            data_sel_o <= map_bus.data_sel;
        end
    end

    // interrupt blocking
    logic access_q;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            access_q <= 1'b0;
        end else if (cfg_wr || cfg_rd) begin
            access_q <= 1'b1; // R21
        end else if (instr_cycle_i) begin
            access_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            int_block_o <= 1'b0;
        end else begin
            int_block_o <= (state_q != SW_IDLE) || access_q || cfg_wr || cfg_rd; // R21
        end
    end

    // read port
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= RDATA_IDLE;
        end else if (cfg_rd) begin
            sfr_rdata_o[ARM_BIT] <= (state_q == SW_ARMED);
            sfr_rdata_o[COMMIT_BIT] <= 1'b0; // R8
            sfr_rdata_o[RSV_HI_BIT:RSV_LO_BIT] <= RSV_READ; // R9
            sfr_rdata_o[FWE_BIT] <= stage_fwe_q;
            sfr_rdata_o[MIRROR_BIT] <= pin_sync_q; // R13
            sfr_rdata_o[SWAP_BIT] <= stage_swap_q;
        end else begin
            sfr_rdata_o <= RDATA_IDLE;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_arm_self_clear: assert property (arm_expire |=> (state_q == SW_IDLE)) // R5
        else $error("arm bit did not expire");
    a_commit_reads_zero: assert property (cfg_rd |=> !sfr_rdata_o[COMMIT_BIT]) // R8
        else $error("commit bit read back as one");
    a_mirror_read: assert property (cfg_rd |=> (sfr_rdata_o[MIRROR_BIT] == $past(pin_sync_q))) // R13
        else $error("mirror bit does not follow pin");
    a_swap_locked: assert property ((!apply && !hw_load) |=> $stable(act_q[SWAP_IDX])) // R12
        else $error("swap changed outside unlock");
    a_pin_low_clear: assert property ((instr_cycle_i && !pin_sync_q && !hw_load) |=> !act_q[FWE_IDX]) // R11
        else $error("write enable not cleared by low pin");
    a_strap_load: assert property (hw_load |=> (act_q[FWE_IDX] == $past(pin_sync_q))) // R3
        else $error("strap not latched");
    a_switch_apply: assert property (((state_q == SW_ARMED) && commit_wr && !pd_release)
        |=> (state_q == SW_SWITCHING) ##1 (act_q[SWAP_IDX] == $past(act_q[SWAP_IDX]))) // R7
        else $error("mode switched too early");
    a_apply_value: assert property (apply |=> ##1 (chipmode_o[0] == $past(stage_swap_q, 2))) // R20
        else $error("chipmode output wrong after switch");
    a_int_block: assert property ((cfg_wr || cfg_rd) |=> int_block_o) // R21
        else $error("interrupt not blocked after access");
    a_pin_blocks_set: assert property ((cfg_wr && !pin_sync_q && !hw_load) |=> !stage_fwe_q) // R14
        else $error("write enable set while pin low");
    a_powerdown_cancel: assert property (pd_release |=> (state_q == SW_IDLE)) // R24
        else $error("unlock survived powerdown release");
    a_boot_rom_map: assert property ((act_q[SWAP_IDX] && (code_addr_i <= BOOT_ROM_END))
        |=> (code_sel_o == CODE_BOOT_ROM)) // R17
        else $error("boot rom not selected");
    a_flash_data_map: assert property (act_q[SWAP_IDX] |=> (data_sel_o == DATA_EXT_FLASH)) // R19
        else $error("data space not on flash");

    c_unlock_done: cover property ((state_q == SW_ARMED) ##1 (state_q == SW_SWITCHING) ##[1:20] apply);
    c_arm_lapsed: cover property (arm_expire);
    c_powerdown: cover property (pd_release);
    c_programming: cover property (chipmode_o == CM_PROGRAMMING);

endmodule : chipmode_select_control

// ---- core_model.sv ----
module core_model
    import chipmode_pkg::*;
#(
    parameter int INSTR_LEN = 4
) (
    input wire logic clk_i,
    output logic instr_cycle_o,
    output logic [7:0] sfr_addr_o,
    output logic sfr_wr_o,
    output logic sfr_rd_o,
    output logic [7:0] sfr_wdata_o,
    input wire logic [7:0] sfr_rdata_i,
    output logic prog_pin_o,
    output logic pd_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int phase = 0;

    initial begin
        instr_cycle_o = 1'b0;
        sfr_addr_o = 8'h00;
        sfr_wr_o = 1'b0;
        sfr_rd_o = 1'b0;
        sfr_wdata_o = 8'h00;
        prog_pin_o = 1'b1;
        pd_n_o = 1'b1;
    end

    // instruction boundary pulse every INSTR_LEN clocks
    always @(posedge clk_i) begin
        #1;
        phase = (phase + 1) % INSTR_LEN;
        instr_cycle_o = (phase == 0);
    end

    // one register write; arm and commit come from consecutive calls
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        sfr_addr_o = a;
        sfr_wdata_o = d;
        sfr_wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        sfr_wr_o = 1'b0;
        sfr_addr_o = ~a;
        sfr_wdata_o = ~d;
    endtask : wr

    // one register read, data taken the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        sfr_addr_o = a;
        sfr_rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        d = sfr_rdata_i;
        sfr_rd_o = 1'b0;
        sfr_addr_o = ~a;
    endtask : rd

    task automatic set_pins(input logic prog, input logic pd_n);
        @(posedge clk_i);
        #1;
        prog_pin_o = prog;
        pd_n_o = pd_n;
    endtask : set_pins

endmodule : core_model

// ---- tb.sv ----
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module tb
    import chipmode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i;
    logic reset_n_i;
    logic instr_cycle_i;
    logic [7:0] sfr_addr_i;
    logic sfr_wr_i;
    logic sfr_rd_i;
    logic [7:0] sfr_wdata_i;
    logic [7:0] sfr_rdata_o;
    logic prog_enable_pin_i;
    logic hw_powerdown_pin_n_i;
    logic onchip_ram_map_enable_i;
    logic [15:0] code_addr_i;
    logic [15:0] data_addr_i;
    chipmode_e chipmode_o;
    logic flash_write_allow_o;
    code_target_e code_sel_o;
    data_target_e data_sel_o;
    logic int_block_o;
    int error_cnt = 0;
    int comparisons = 0;

    chipmode_select_control dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .instr_cycle_i(instr_cycle_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .prog_enable_pin_i(prog_enable_pin_i), .hw_powerdown_pin_n_i(hw_powerdown_pin_n_i),
        .onchip_ram_map_enable_i(onchip_ram_map_enable_i), .code_addr_i(code_addr_i),
        .data_addr_i(data_addr_i), .chipmode_o(chipmode_o), .flash_write_allow_o(flash_write_allow_o),
        .code_sel_o(code_sel_o), .data_sel_o(data_sel_o), .int_block_o(int_block_o)
    );

    core_model u_core (
        .clk_i(clk_i), .instr_cycle_o(instr_cycle_i), .sfr_addr_o(sfr_addr_i),
        .sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i),
        .sfr_rdata_i(sfr_rdata_o), .prog_pin_o(prog_enable_pin_i), .pd_n_o(hw_powerdown_pin_n_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic wait_instr();
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            if (instr_cycle_i === 1'b1) begin
                return;
            end
        end
        error_cnt++;
        test_done();
    endtask : wait_instr

    task automatic wait_mode(input chipmode_e exp);
        for (int i = 0; i < 16 && chipmode_o !== exp; i++) begin
            @(posedge clk_i);
            #1;
        end
        `CHK(chipmode_o, exp)
        if (chipmode_o !== exp) begin
            test_done();
        end
    endtask : wait_mode

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_core.rd(a, d);
        `CHK(d, exp)
    endtask : rd_chk

    // arm with new values, commit next instruction, mode holds one more cycle
    task automatic switch_mode(input logic [7:0] v, input chipmode_e exp);
        chipmode_e old;
        old = chipmode_o;
        wait_instr();
        u_core.wr(CFG_ADDR, 8'h80 | v);
        `CHK(int_block_o, 1'b1)
        wait_instr();
        u_core.wr(CFG_ADDR, 8'h40);
        wait_instr();
        @(posedge clk_i);
        #1;
        `CHK(chipmode_o, old)
        wait_mode(exp);
    endtask : switch_mode

    task automatic map_chk(input logic [15:0] ca, input logic [15:0] da, input logic ren,
                           input code_target_e ec, input data_target_e ed);
        @(posedge clk_i);
        #1;
        code_addr_i = ca;
        data_addr_i = da;
        onchip_ram_map_enable_i = ren;
        @(posedge clk_i);
        #1;
        `CHK(code_sel_o, ec)
        `CHK(data_sel_o, ed)
    endtask : map_chk

    task automatic s_strap();
        wait_mode(CM_BOOTSTRAP);
        `CHK(flash_write_allow_o, 1'b1)
        rd_chk(CFG_ADDR, 8'h06);
        rd_chk(8'hb3, 8'h00);
    endtask : s_strap

    task automatic s_plain_write();
        u_core.wr(CFG_ADDR, 8'h39);
        repeat (12) @(posedge clk_i);
        #1;
        `CHK(chipmode_o, CM_BOOTSTRAP)
        rd_chk(CFG_ADDR, 8'h06);
    endtask : s_plain_write

    task automatic s_program_map();
        switch_mode(8'h05, CM_PROGRAMMING);
        `CHK(flash_write_allow_o, 1'b1)
        map_chk(16'h01ff, 16'h0000, 1'b0, CODE_BOOT_ROM, DATA_EXT_FLASH);
        map_chk(16'h0200, 16'hffff, 1'b0, CODE_EXT_SRAM, DATA_EXT_FLASH);
        map_chk(16'hf3ff, 16'hf400, 1'b1, CODE_EXT_SRAM, DATA_EXT_FLASH);
        map_chk(16'hf400, 16'h1234, 1'b0, CODE_ONCHIP_RAM, DATA_EXT_FLASH);
    endtask : s_program_map

    task automatic s_expire();
        wait_instr();
        u_core.wr(CFG_ADDR, 8'h80);
        repeat (3) wait_instr();
        rd_chk(CFG_ADDR, 8'h07);
        u_core.wr(CFG_ADDR, 8'h40);
        repeat (12) @(posedge clk_i);
        #1;
        `CHK(chipmode_o, CM_PROGRAMMING)
    endtask : s_expire

    task automatic s_pin_low();
        u_core.set_pins(1'b0, 1'b1);
        wait_mode(CM_RAM_EXEC);
        `CHK(flash_write_allow_o, 1'b0)
        rd_chk(CFG_ADDR, 8'h01);
        switch_mode(8'h05, CM_RAM_EXEC);
    endtask : s_pin_low

    task automatic s_powerdown();
        u_core.set_pins(1'b1, 1'b1);
        u_core.set_pins(1'b1, 1'b0);
        repeat (4) @(posedge clk_i);
        u_core.set_pins(1'b1, 1'b1);
        wait_mode(CM_PROGRAMMING);
        rd_chk(CFG_ADDR, 8'h07);
    endtask : s_powerdown

    task automatic s_normal_map();
        switch_mode(8'h00, CM_NORMAL);
        `CHK(flash_write_allow_o, 1'b0)
        map_chk(16'h0000, 16'hf400, 1'b1, CODE_EXT_FLASH, DATA_ONCHIP_RAM);
        map_chk(16'hffff, 16'hf400, 1'b0, CODE_EXT_FLASH, DATA_EXT_SRAM);
        map_chk(16'h0100, 16'hf3ff, 1'b1, CODE_EXT_FLASH, DATA_EXT_SRAM);
    endtask : s_normal_map

    initial begin
        reset_n_i = 1'b0;
        onchip_ram_map_enable_i = 1'b0;
        code_addr_i = 16'h0000;
        data_addr_i = 16'h0000;
        repeat (20) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        s_strap();
        s_plain_write();
        s_program_map();
        s_expire();
        s_pin_low();
        s_powerdown();
        s_normal_map();
        test_done();
    end

endmodule : tb
